// [acprm_pkg.sv]
// Package for the amplifier control-port register map.
// Assumes a byte-wide register access port in the core clock domain.
package acprm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the base page
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PAGE_SELECT = 8'h00; // Page selector.
  localparam logic [7:0] OFS_RESET_CONTROL = 8'h01;
  localparam logic [7:0] OFS_DEVICE_CONTROL_ONE = 8'h02;
  localparam logic [7:0] OFS_DEVICE_CONTROL_TWO = 8'h03;
  localparam logic [7:0] OFS_PAGE_INCREMENT_CONTROL = 8'h0f;
  localparam logic [7:0] OFS_SIGNAL_CHANNEL_CONTROL = 8'h28;
  localparam logic [7:0] OFS_CLOCK_DETECT_CONTROL = 8'h29;
  localparam logic [7:0] OFS_SERIAL_OUT_SELECT = 8'h30;
  localparam logic [7:0] OFS_AUDIO_SERIAL_CONTROL = 8'h31;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL_ONE = 8'h33;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL_TWO = 8'h34;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL_THREE = 8'h35;
  localparam logic [7:0] OFS_SAMPLE_RATE_MONITOR = 8'h37;
  localparam logic [7:0] OFS_BIT_CLOCK_MONITOR = 8'h38;
  localparam logic [7:0] OFS_CLOCK_DETECT_STATE = 8'h39;
  localparam logic [7:0] OFS_VOLUME_CONTROL_ONE = 8'h4c;
  localparam logic [7:0] OFS_VOLUME_CONTROL_TWO = 8'h4e;
  localparam logic [7:0] OFS_VOLUME_CONTROL_THREE = 8'h4f;
  localparam logic [7:0] OFS_SILENCE_DETECT_CONTROL = 8'h50;
  localparam logic [7:0] OFS_SILENCE_DETECT_TIME = 8'h51;
  localparam logic [7:0] OFS_ANALOG_CONTROL = 8'h53;
  localparam logic [7:0] OFS_ANALOG_GAIN = 8'h54;
  localparam logic [7:0] OFS_FILTER_WRITE_CONTROL = 8'h5c;
  localparam logic [7:0] OFS_CONVERTER_CONTROL = 8'h5d;
  localparam logic [7:0] OFS_ADDR_FAULT_PIN_CONTROL = 8'h60;
  localparam logic [7:0] OFS_ADDR_FAULT_PIN_CONFIG = 8'h61;
  localparam logic [7:0] OFS_PROCESSOR_MISC = 8'h66;
  localparam logic [7:0] OFS_DIE_IDENTITY = 8'h67;
  localparam logic [7:0] OFS_POWER_STATE_REPORT = 8'h68;
  localparam logic [7:0] OFS_SILENCE_STATE_REPORT = 8'h69;
  localparam logic [7:0] OFS_PHASE_CONTROL = 8'h6a;
  localparam logic [7:0] OFS_SPREAD_CONTROL_ZERO = 8'h6b;
  localparam logic [7:0] OFS_SPREAD_CONTROL_FOUR = 8'h6f;
  localparam logic [7:0] OFS_CHANNEL_FAULT_REPORT = 8'h70;
  localparam logic [7:0] OFS_GLOBAL_FAULT_REPORT_ONE = 8'h71;
  localparam logic [7:0] OFS_GLOBAL_FAULT_REPORT_TWO = 8'h72;
  localparam logic [7:0] OFS_THERMAL_WARNING_REPORT = 8'h73;
  localparam logic [7:0] OFS_PIN_CONTROL_ONE = 8'h74;
  localparam logic [7:0] OFS_PIN_CONTROL_TWO = 8'h75;
  localparam logic [7:0] OFS_MISC_CONTROL = 8'h76;
  localparam logic [7:0] OFS_FAULT_CLEAR_REQUEST = 8'h78;
  localparam logic [7:0] OFS_BOOK_SELECT = 8'h7f; // Book selector, page 0.

  // ----------------------------------------------------------------------
  // Reset-control field layout and reset values
  // ----------------------------------------------------------------------
  localparam int RC_FULL_CORE_BIT = 4;
  localparam int RC_REG_ONLY_BIT = 0;
  localparam int RC_KEEP_MSB = 7;
  localparam int RC_KEEP_LSB = 5;
  localparam logic [2:0] RC_KEEP_RESET = 3'h0;
  localparam logic [7:0] RESET_CONTROL_RESET = 8'h00;
  localparam logic [7:0] REG_DEFAULT_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] BOOK_RESET = 8'h00;

  // Number of stored read/write registers and of status inputs.
  localparam int NUM_RW = 31;
  localparam int NUM_RO = 10;

  // Coefficient memory geometry and the cycles taken to clear it.
  localparam int COEF_DEPTH = 256;
  localparam int COEF_AW = 8;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // One register access from the control-port byte engine.
  typedef struct packed {
    logic wr; // Write strobe, one cycle.
    logic rd; // Read strobe, one cycle.
    logic [7:0] addr; // Register offset.
    logic [7:0] wdata; // Write data.
  } acprm_req_type;

  // Coefficient memory access from the processor side.
  typedef struct packed {
    logic wr; // Write strobe.
    logic [COEF_AW-1:0] addr; // Word address.
    logic [7:0] wdata; // Write data.
  } acprm_coef_type;

  // Clearing engine states, Gray coded along idle, clear, done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CLEAR = 2'b01,
    ST_DONE = 2'b11
  } acprm_state_type;

endpackage : acprm_pkg

// [acprm_regmap.sv]
// Control-port register map of a digital-input stereo class-D amplifier.
// Assumes a byte engine in front that turns bus transfers into single-cycle
// read and write strobes on mclk, and status inputs synchronous to mclk.
//
// Operation
// - Bit 4 resets whole core and registers.
// - Full core reset clears coefficient memory.
// - Bit 0 restores control registers only.
// - Register-only reset keeps coefficient memory intact.
// - Both reset bits self-clear, write-only.
// - Bits 7-5 stored; bits 3-1 read zero.
// - Reset control at 1h, resets to 00h.
// - Offset 0 selects page, 7fh selects book.
`timescale 1ns/1ps

module acprm_regmap
  import acprm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire acprm_pkg::acprm_req_type req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [7:0] status_in [acprm_pkg::NUM_RO],
  input wire acprm_pkg::acprm_coef_type coef_req,
  output logic [7:0] coef_rdata,
  output logic [7:0] rw_regs [acprm_pkg::NUM_RW],
  output logic [7:0] page_sel,
  output logic [7:0] book_sel,
  output logic core_reset,
  output logic coef_busy
);
  import acprm_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // All flip-flop state of the block, except the coefficient array.
  typedef struct packed {
    logic [2:0] keep; // Stored reserved bits 7-5 of reset control.
    logic [NUM_RW-1:0][7:0] regs; // Read/write register file.
    logic [7:0] page; // Current page.
    logic [7:0] book; // Current book.
    logic [7:0] rdata; // Read data.
    logic rvalid; // Read answer strobe.
    logic core_rst; // Full core reset pulse.
    acprm_state_type st; // Coefficient clearing state.
    logic [COEF_AW-1:0] clr_addr; // Clearing address.
    logic [7:0] coef_rd; // Coefficient read data.
  } acprm_state_struct_type;

  acprm_state_struct_type state_q; // Registered state.
  acprm_state_struct_type state_d; // Next state.
  logic [7:0] coef_mem [COEF_DEPTH]; // Coefficient memory.

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  // Maps an offset to a read/write register slot, or -1 if none.
  function automatic int rw_index(input logic [7:0] a);
    int idx;
    idx = -1;
    if (a == OFS_DEVICE_CONTROL_ONE) idx = 0;
    else if (a == OFS_DEVICE_CONTROL_TWO) idx = 1;
    else if (a == OFS_PAGE_INCREMENT_CONTROL) idx = 2;
    else if (a == OFS_SIGNAL_CHANNEL_CONTROL) idx = 3;
    else if (a == OFS_CLOCK_DETECT_CONTROL) idx = 4;
    else if (a == OFS_SERIAL_OUT_SELECT) idx = 5;
    else if (a == OFS_AUDIO_SERIAL_CONTROL) idx = 6;
    else if (a == OFS_SERIAL_PORT_CONTROL_ONE) idx = 7;
    else if (a == OFS_SERIAL_PORT_CONTROL_TWO) idx = 8;
    else if (a == OFS_SERIAL_PORT_CONTROL_THREE) idx = 9;
    else if (a == OFS_VOLUME_CONTROL_ONE) idx = 10;
    else if (a == OFS_VOLUME_CONTROL_TWO) idx = 11;
    else if (a == OFS_VOLUME_CONTROL_THREE) idx = 12;
    else if (a == OFS_SILENCE_DETECT_CONTROL) idx = 13;
    else if (a == OFS_SILENCE_DETECT_TIME) idx = 14;
    else if (a == OFS_ANALOG_CONTROL) idx = 15;
    else if (a == OFS_ANALOG_GAIN) idx = 16;
    else if (a == OFS_FILTER_WRITE_CONTROL) idx = 17;
    else if (a == OFS_CONVERTER_CONTROL) idx = 18;
    else if (a == OFS_ADDR_FAULT_PIN_CONTROL) idx = 19;
    else if (a == OFS_ADDR_FAULT_PIN_CONFIG) idx = 20;
    else if (a == OFS_PROCESSOR_MISC) idx = 21;
    else if (a >= OFS_PHASE_CONTROL && a <= OFS_SPREAD_CONTROL_FOUR)
      idx = 22 + int'(a - OFS_PHASE_CONTROL);
    else if (a == OFS_PIN_CONTROL_ONE) idx = 28;
    else if (a == OFS_PIN_CONTROL_TWO) idx = 29;
    else if (a == OFS_MISC_CONTROL) idx = 30;
    return idx;
  endfunction : rw_index

  // Maps an offset to a status input slot, or -1 if none.
  function automatic int ro_index(input logic [7:0] a);
    int idx;
    idx = -1;
    if (a >= OFS_SAMPLE_RATE_MONITOR && a <= OFS_CLOCK_DETECT_STATE)
      idx = int'(a - OFS_SAMPLE_RATE_MONITOR);
    else if (a >= OFS_DIE_IDENTITY && a <= OFS_SILENCE_STATE_REPORT)
      idx = 3 + int'(a - OFS_DIE_IDENTITY);
    else if (a >= OFS_CHANNEL_FAULT_REPORT &&
             a <= OFS_THERMAL_WARNING_REPORT)
      idx = 6 + int'(a - OFS_CHANNEL_FAULT_REPORT);
    return idx;
  endfunction : ro_index

  // True when an access reaches the base control-port page.
  logic base_page;
  assign base_page = (state_q.page == PAGE_RESET) &&
                     (state_q.book == BOOK_RESET);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Handles reads, writes, the two reset requests and memory clearing.
  always_comb begin
    int wi;
    int ri;
    logic reg_rst;
    wi = rw_index(req.addr);
    ri = ro_index(req.addr);
    reg_rst = 1'b0;
    state_d = state_q;
    state_d.rvalid = req.rd;
    state_d.core_rst = 1'b0;

    // Read path; unlisted offsets answer zero and change nothing.
    if (req.rd) begin
      state_d.rdata = 8'h00;
      if (req.addr == OFS_PAGE_SELECT) begin
        state_d.rdata = state_q.page;
      end else if (req.addr == OFS_BOOK_SELECT &&
                   state_q.page == PAGE_RESET) begin
        state_d.rdata = state_q.book;
      end else if (base_page) begin
        if (req.addr == OFS_RESET_CONTROL) begin
          // Request bits read zero, bits 3-1 read zero.
          state_d.rdata = {state_q.keep, 5'b0_0000};
        end else if (wi >= 0) begin
          state_d.rdata = state_q.regs[wi];
        end else if (ri >= 0) begin
          state_d.rdata = status_in[ri];
        end
      end
    end

    // Write path.
    if (req.wr) begin
      if (req.addr == OFS_PAGE_SELECT) begin
        state_d.page = req.wdata;
      end else if (req.addr == OFS_BOOK_SELECT &&
                   state_q.page == PAGE_RESET) begin
        state_d.book = req.wdata;
      end else if (base_page) begin
        if (req.addr == OFS_RESET_CONTROL) begin
          state_d.keep = req.wdata[RC_KEEP_MSB:RC_KEEP_LSB];
          // Request bits are never stored, so they clear themselves.
          reg_rst = req.wdata[RC_REG_ONLY_BIT];
          if (req.wdata[RC_FULL_CORE_BIT]) begin
            reg_rst = 1'b1;
            state_d.core_rst = 1'b1;
            state_d.st = ST_CLEAR;
            state_d.clr_addr = '0;
          end
        end else if (wi >= 0) begin
          state_d.regs[wi] = req.wdata;
        end
        // Writes elsewhere are dropped; the host must avoid them.
      end
    end

    // Control registers return to initial values; memory is untouched.
    if (reg_rst) begin
      state_d.keep = RC_KEEP_RESET;
      state_d.regs = '0;
      state_d.page = PAGE_RESET;
      state_d.book = BOOK_RESET;
    end

    // Coefficient clearing walks every word once after a full reset.
    case (state_q.st)
      ST_CLEAR: begin
        state_d.clr_addr = state_q.clr_addr + 1'b1;
        if (state_q.clr_addr == COEF_AW'(COEF_DEPTH - 1)) begin
          state_d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d.st = ST_IDLE;
      end
      default: begin
        state_d.st = state_q.st;
      end
    endcase
    if (req.wr && req.addr == OFS_RESET_CONTROL && base_page &&
        req.wdata[RC_FULL_CORE_BIT]) begin
      state_d.st = ST_CLEAR; // A fresh request restarts the clear.
      state_d.clr_addr = '0;
    end

    // Coefficient read data.
    state_d.coef_rd = coef_mem[coef_req.addr];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Registers the whole state; reset control takes 00h.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
      state_q.keep <= RC_KEEP_RESET;
      state_q.page <= PAGE_RESET;
      state_q.book <= BOOK_RESET;
      state_q.st <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient memory
  // ----------------------------------------------------------------------
  // Clearing has priority over processor writes while it runs.
  always_ff @(posedge mclk) begin
    if (state_q.st == ST_CLEAR) begin
      coef_mem[state_q.clr_addr] <= 8'h00;
    end else if (coef_req.wr) begin
      coef_mem[coef_req.addr] <= coef_req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Unpack the register file for the rest of the core.
  always_comb begin
    for (int i = 0; i < NUM_RW; i++) begin
      rw_regs[i] = state_q.regs[i];
    end
  end

  assign rdata = state_q.rdata;
  assign rvalid = state_q.rvalid;
  assign page_sel = state_q.page;
  assign book_sel = state_q.book;
  assign core_reset = state_q.core_rst;
  assign coef_busy = (state_q.st == ST_CLEAR);
  assign coef_rdata = state_q.coef_rd;

endmodule : acprm_regmap

// [acprm_regmap_properties.sv]
// Concurrent checks on the ports of the control-port register map.
// Assumes it is bound onto acprm_regmap, with acprm_pkg compiled first.
`timescale 1ns/1ps

module acprm_regmap_properties
  import acprm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire acprm_pkg::acprm_req_type req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [7:0] rw_regs [acprm_pkg::NUM_RW],
  input wire logic [7:0] page_sel,
  input wire logic [7:0] book_sel,
  input wire logic core_reset,
  input wire logic coef_busy
);
  // ------------------------------------------------------------------
  // Clocking and helpers
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic on_base; // The base page of book zero is selected.
  logic rc_wr; // An accepted write to the reset-control register.
  assign on_base = (page_sel == 8'h00) && (book_sel == 8'h00);
  assign rc_wr = req.wr && (req.addr == OFS_RESET_CONTROL) && on_base;

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  AST_FULL_RESET: assert property (rc_wr && req.wdata[4] |=>
    core_reset && coef_busy && rw_regs[0] == 8'h00)
    else $error("full reset did not reach core and registers");
  AST_CLEAR_LEN: assert property ($rose(coef_busy) |->
    ##255 coef_busy ##1 !coef_busy)
    else $error("memory clear did not last 256 cycles");
  AST_REG_RESET: assert property (rc_wr && req.wdata[0] &&
    !req.wdata[4] |=> rw_regs[0] == 8'h00 && rw_regs[30] == 8'h00)
    else $error("register reset left a register set");
  AST_KEEP_RAM: assert property (rc_wr && req.wdata[0] &&
    !req.wdata[4] && !coef_busy |=> !core_reset && !coef_busy)
    else $error("register reset disturbed the memory");
  AST_SELF_CLEAR: assert property (core_reset |=> !core_reset)
    else $error("core reset pulse longer than one cycle");
  AST_RC_READ: assert property (req.rd &&
    req.addr == OFS_RESET_CONTROL |=> rvalid && rdata[4:0] == 5'h00)
    else $error("reset control low bits did not read zero");
  AST_PAGE_SEL: assert property (req.wr &&
    req.addr == OFS_PAGE_SELECT |=> page_sel == $past(req.wdata))
    else $error("page select not taken");
  AST_UNLISTED: assert property (req.rd &&
    req.addr == 8'h04 |=> rvalid && rdata == 8'h00)
    else $error("unlisted offset did not read zero");
  AST_RW_STORE: assert property (req.wr && on_base &&
    req.addr == OFS_DEVICE_CONTROL_ONE |=> rw_regs[0] == $past(req.wdata))
    else $error("register write not stored");
  AST_RV_CAUSE: assert property (rvalid |-> $past(req.rd))
    else $error("read answer without a read");
endmodule : acprm_regmap_properties

bind acprm_regmap acprm_regmap_properties props_u (.mclk(mclk),
  .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .rw_regs(rw_regs), .page_sel(page_sel), .book_sel(book_sel),
  .core_reset(core_reset), .coef_busy(coef_busy));

// [acprm_host.sv]
// Host model that issues single register reads and writes.
// Assumes the register map takes one-cycle strobes on rising mclk.
`timescale 1ns/1ps

module acprm_host
  import acprm_pkg::*;
(
  input wire logic mclk,
  output acprm_pkg::acprm_req_type req
);
  initial req = '0;

  // One write to a listed offset; the strobe is dropped after one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask : wr

  // One read; the answer is collected by the bench monitor.
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
  endtask : rd

  // Move to page zero before the book changes.
  task automatic set_book(input logic [7:0] b);
    wr(OFS_PAGE_SELECT, 8'h00);
    wr(OFS_BOOK_SELECT, b);
  endtask : set_book
endmodule : acprm_host

// [acprm_regmap_tb_top.sv]
// Self-checking bench for the control-port register map.
// Assumes acprm_pkg, the design, the checker and the host model.
`timescale 1ns/1ps

module acprm_regmap_tb_top;
  import acprm_pkg::*;
  logic mclk;
  logic sys_rst;
  acprm_req_type req;
  acprm_coef_type coef_req;
  logic [7:0] status_in [NUM_RO];
  logic [7:0] rw_regs [NUM_RW];
  logic [7:0] rdata, coef_rdata, page_sel, book_sel, dv, dq;
  logic rvalid, core_reset, coef_busy;
  int mismatches;
  int n_compared;
  logic [7:0] exp_q [$]; // Expected read answers, oldest first.
  logic [7:0] rw_ofs [4] = '{8'h02, 8'h0f, 8'h6f, 8'h76};
  int rw_idx [4] = '{0, 2, 27, 30};

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  acprm_host host_u (.mclk(mclk), .req(req));
  acprm_regmap dut_u (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .status_in(status_in),
    .coef_req(coef_req), .coef_rdata(coef_rdata), .rw_regs(rw_regs),
    .page_sel(page_sel), .book_sel(book_sel), .core_reset(core_reset),
    .coef_busy(coef_busy));

  // ------------------------------------------------------------------
  // Compare, read and memory tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask : rd

  task automatic coef_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    coef_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    coef_req.wr <= 1'b0;
  endtask : coef_wr

  task automatic coef_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    coef_req.addr <= a;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("coef word", e, coef_rdata);
  endtask : coef_chk

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Each read answer is matched against the oldest expectation.
  always @(negedge mclk) begin
    if (rvalid === 1'b1) begin
      dq = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      chk("read data", dq, rdata);
    end
  end

  // Bounds the whole run.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("wrong value run state expected done seen running");
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    coef_req = '0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(53367));
    foreach (status_in[i]) status_in[i] = 8'($urandom);
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_RESET_CONTROL, 8'h00);
    // Look between edges so the registered outputs have settled.
    @(negedge mclk);
    foreach (rw_regs[i]) chk("reset value", 8'h00, rw_regs[i]);
    $display("reset value test done");
    for (int i = 0; i < 4; i++) begin
      dv = 8'($urandom);
      host_u.wr(rw_ofs[i], dv);
      rd(rw_ofs[i], dv);
      chk("stored register", dv, rw_regs[rw_idx[i]]);
    end
    rd(OFS_SAMPLE_RATE_MONITOR, status_in[0]);
    rd(OFS_SILENCE_STATE_REPORT, status_in[5]);
    host_u.wr(OFS_CLOCK_DETECT_STATE, ~status_in[2]);
    rd(OFS_CLOCK_DETECT_STATE, status_in[2]);
    rd(OFS_THERMAL_WARNING_REPORT, status_in[9]);
    rd(8'h04, 8'h00);
    $display("access test done");
    host_u.wr(OFS_RESET_CONTROL, 8'hee);
    rd(OFS_RESET_CONTROL, 8'he0);
    coef_wr(8'h05, 8'ha5);
    host_u.wr(OFS_DEVICE_CONTROL_TWO, 8'h3c);
    host_u.wr(OFS_RESET_CONTROL, 8'h01);
    rd(OFS_RESET_CONTROL, 8'h00);
    rd(OFS_DEVICE_CONTROL_TWO, 8'h00);
    coef_chk(8'h05, 8'ha5);
    $display("register reset test done");
    host_u.wr(OFS_DEVICE_CONTROL_TWO, 8'h3c);
    host_u.wr(OFS_RESET_CONTROL, 8'hf0);
    rd(OFS_DEVICE_CONTROL_TWO, 8'h00);
    rd(OFS_RESET_CONTROL, 8'h00);
    // Word 1 is written while the clear still runs, so the write is dropped and it reads zero.
    coef_wr(8'h01, 8'h77);
    for (int n = 0; n < 400 && coef_busy !== 1'b0; n++) @(negedge mclk);
    chk("coef busy", 8'h00, {7'h00, coef_busy});
    coef_chk(8'h05, 8'h00);
    coef_chk(8'h01, 8'h00);
    $display("full reset test done");
    host_u.wr(OFS_DEVICE_CONTROL_ONE, 8'h5a);
    host_u.wr(OFS_PAGE_SELECT, 8'h2a);
    rd(OFS_PAGE_SELECT, 8'h2a);
    rd(OFS_DEVICE_CONTROL_ONE, 8'h00);
    host_u.set_book(8'h03);
    @(negedge mclk);
    chk("book select", 8'h03, book_sel);
    rd(OFS_BOOK_SELECT, 8'h03);
    rd(OFS_DEVICE_CONTROL_ONE, 8'h00);
    host_u.set_book(8'h00);
    rd(OFS_DEVICE_CONTROL_ONE, 8'h5a);
    $display("page and book test done");
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_DEVICE_CONTROL_ONE, 8'h00);
    repeat (4) @(posedge mclk);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : acprm_regmap_tb_top
